// ===== tb/emc_phy_model.sv
// Management-side PHY model that answers read words with a fixed value
`timescale 1ns/1ps
module emc_phy_model #(
    parameter logic [15:0] READ_VALUE = 16'hC35A
) (
    input  wire logic rst,
    input  wire logic mdc,
    input  wire logic mdio_o,
    output logic      mdio_i
);
    int   bit_cnt;  // Clock rises seen in the current word
    logic is_read;  // Read flag taken from the third bit
    initial begin
        bit_cnt = 0;
        is_read = 1'b0;
        mdio_i = 1'b0;
    end
    // ----------------------------------------
    // Bit counting and read flag capture
    // ----------------------------------------
    always @(posedge mdc or posedge rst) begin
        if (rst) begin
            bit_cnt <= 0;
            is_read <= 1'b0;
        end else begin
            bit_cnt <= (bit_cnt == 32) ? 1 : bit_cnt + 1;
            // Data from the block is stable at the rise
            if (bit_cnt == 2 || bit_cnt == 32) begin
                is_read <= mdio_o;
            end
        end
    end
    // ----------------------------------------
    // Data launch after each falling edge
    // ----------------------------------------
    always @(negedge mdc) begin
        if (is_read && bit_cnt >= 16 && bit_cnt < 32) begin
            mdio_i <= READ_VALUE[31 - bit_cnt];
        end else begin
            // Released line: never repeats the last value
            mdio_i <= ~mdio_i;
        end
    end
endmodule

// ===== tb/tb_eth_mac_rx_config_mdc.sv
// Self-checking bench for the receive filter and management clock block
`timescale 1ns/1ps
module tb_eth_mac_rx_config_mdc;
    import emc_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    emc_rx_s     rx_in = '0;
    logic [6:0]  side = 7'h00;   // fcs, csum, da, hash, type, caf, pfc
    emc_mem_s    mem_out;
    emc_done_s   frame_done;
    logic        csum_engine_en, pause_tx_req, mdc, mdio_o, mdio_oe, mdio_i;
    logic [1:0]  bus_width_sel;
    logic [15:0] pause_quanta, cur_type, cur_qnt, first_addr, cur_ofs;
    logic [31:0] rv;              // Last read word
    logic        seen_pause;
    int          wr_cnt, fail_count, checks;
    always #50 clock = ~clock;
    emc_rx_cfg u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_in(rx_in),
        .fcs_bad(side[6]), .csum_bad(side[5]), .da_match(side[4]), .hash_match(side[3]),
        .type_match(side[2]), .copy_all_frames(side[1]), .pfc_negotiated(side[0]),
        .mem_out(mem_out), .frame_done(frame_done), .csum_engine_en(csum_engine_en),
        .bus_width_sel(bus_width_sel), .pause_tx_req(pause_tx_req),
        .pause_quanta(pause_quanta), .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
        .mdio_i(mdio_i));
    emc_phy_model u_phy (.rst(rst), .mdc(mdc), .mdio_o(mdio_o), .mdio_i(mdio_i));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    function automatic logic [7:0] byte_at(input logic [15:0] i);
        case (i)
            16'h000C: return cur_type[15:8];
            16'h000D: return cur_type[7:0];
            16'h000E: return 8'h00;
            16'h000F: return (cur_type == 16'h8808) ? 8'h01 : 8'h5A;
            16'h0010: return cur_qnt[15:8];
            16'h0011: return cur_qnt[7:0];
            default:  return i[7:0] ^ 8'hA5;
        endcase
    endfunction
    // Memory write monitor: counts bytes and checks their content
    // Sampled mid-cycle, where the registered outputs are settled
    always @(negedge clock) begin
        if (mem_out.vld === 1'b1) begin
            if (wr_cnt == 0) first_addr = mem_out.addr;
            check(mem_out.data, byte_at(mem_out.addr - cur_ofs));
            wr_cnt++;
        end
        if (pause_tx_req === 1'b1) seen_pause = 1'b1;
    end
    // Sends one frame of n bytes; the verdict is returned in dn
    task automatic send_frame(input int n, input logic [15:0] typ, qnt, input logic [6:0] fl,
                              output emc_done_s dn);
        cur_type = typ;
        cur_qnt = qnt;
        wr_cnt = 0;
        seen_pause = 1'b0;
        @(posedge clock);
        side <= fl;
        for (int i = 0; i < n; i++) begin
            rx_in <= '{vld: 1'b1, last: (i == n - 1), data: byte_at(16'(i))};
            @(posedge clock);
        end
        rx_in <= '0;
        #1 dn = frame_done;
        repeat (3) @(posedge clock);
        side <= 7'h00;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        reg_read(OFS_CFG);
        check(rv, 32'h0008_0000);
        reg_read(8'h10);
        check(rv, 32'h0);
        reg_write(OFS_CFG, 32'hFF9F_FFFF);
        reg_read(OFS_CFG);
        check(rv, 32'h019F_E000);
        check({csum_engine_en, bus_width_sel}, 3'h4);
        repeat (20) @(posedge clock);
        check(mdc, 1'b0);
    endtask
    task automatic t_mdc(input int code);
        int half[8] = '{4, 8, 16, 24, 32, 48, 48, 48};
        int rises = 0;
        int highs = 0;
        logic prev = 1'b0;
        reg_write(OFS_CFG, 32'(code) << BIT_DIV_LO);
        reg_write(OFS_MAN, 32'h2000_0000);
        for (int k = 0; k < 64 * half[code] + 8; k++) begin
            @(posedge clock);
            #1;
            if (mdc === 1'b1) highs++;
            if (mdc === 1'b1 && prev === 1'b0) rises++;
            prev = mdc;
        end
        check(rises, 32);
        check(highs, 32 * half[code]);
        check({mdc, mdio_oe}, 2'b00);
        reg_read(OFS_STAT);
        check(rv, 32'h0);
        reg_read(OFS_MAN);
        check(rv[15:0], 16'hC35A);
    endtask
    task automatic t_frames;
        emc_done_s dn;
        reg_write(OFS_CFG, 32'h0000_8000);
        cur_ofs = 16'h0002;
        send_frame(30, 16'h000C, 16'h0, 7'h10, dn);
        check({dn.commit, dn.len}, {1'b1, 16'h001E});
        check({wr_cnt[7:0], first_addr}, {8'h1E, 16'h0002});
        reg_write(OFS_CFG, 32'h0002_C000);
        cur_ofs = 16'h0003;
        send_frame(30, 16'h000C, 16'h0, 7'h10, dn);
        check({dn.commit, dn.len}, {1'b1, 16'h001A});
        check({wr_cnt[7:0], first_addr}, {8'h1A, 16'h0003});
        cur_ofs = 16'h0;
        reg_write(OFS_CFG, 32'h0100_0000);
        send_frame(30, 16'h000C, 16'h0, 7'h30, dn);
        check({dn.commit, dn.drop}, 2'b01);
        reg_write(OFS_CFG, 32'h0);
        send_frame(30, 16'h000C, 16'h0, 7'h30, dn);
        check({dn.commit, dn.drop}, 2'b10);
        send_frame(30, 16'h000D, 16'h0, 7'h10, dn);
        check({dn.commit, dn.drop}, 2'b10);
        reg_write(OFS_CFG, 32'h0001_0000);
        send_frame(30, 16'h000C, 16'h0, 7'h10, dn);
        check({dn.commit, dn.drop}, 2'b10);
        send_frame(30, 16'h000D, 16'h0, 7'h10, dn);
        check({dn.commit, dn.drop}, 2'b01);
        send_frame(30, 16'h0600, 16'h0, 7'h10, dn);
        check({dn.commit, dn.drop}, 2'b10);
    endtask
    task automatic t_pause;
        logic [31:0] cf[6] = '{32'h0080_2000, 32'h0080_2000, 32'h0080_2000,
                               32'h0080_2000, 32'h0000_2000, 32'h0080_0000};
        logic [15:0] qn[6] = '{16'h0102, 16'h0102, 16'h0102, 16'h0, 16'h0102, 16'h0102};
        logic [6:0]  fl[6] = '{7'h0E, 7'h10, 7'h11, 7'h10, 7'h08, 7'h10};
        logic [1:0]  ex[6] = '{2'b01, 2'b11, 2'b10, 2'b10, 2'b11, 2'b10};
        logic [31:0] base;
        emc_done_s   dn;
        reg_read(OFS_PCNT);
        base = rv;
        for (int r = 0; r < 6; r++) begin
            reg_write(OFS_CFG, cf[r]);
            send_frame(30, 16'h8808, qn[r], fl[r], dn);
            check({dn.commit, seen_pause}, ex[r]);
            // Quanta of an honoured frame stay on the output until the next frame
            if (ex[r][0]) check(pause_quanta, 16'h0102);
        end
        reg_read(OFS_PCNT);
        check(rv, base + 32'h6);
    endtask
    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (100000) @(posedge clock);
        fail_count++;
        end_sim();
    end
    initial begin
        cur_ofs = 16'h0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        for (int c = 0; c < 8; c++) t_mdc(c);
        t_frames();
        t_pause();
        end_sim();
    end
endmodule

// ===== verilog/emc_pkg.sv
// Constants and carriers for the receive configuration and management clock block
package emc_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CFG   = 8'h00;
    localparam logic [7:0] OFS_MAN   = 8'h04;
    localparam logic [7:0] OFS_STAT  = 8'h08;
    localparam logic [7:0] OFS_PCNT  = 8'h0C;
    // ----------------------------------------
    // Configuration field positions
    // ----------------------------------------
    localparam int BIT_CSUM    = 24;
    localparam int BIT_PCPY    = 23;
    localparam int BIT_BW_LO   = 21;
    localparam int BIT_DIV_LO  = 18;
    localparam int BIT_STRIP   = 17;
    localparam int BIT_LENDIS  = 16;
    localparam int BIT_OFS_LO  = 14;
    localparam int BIT_PEN     = 13;
    localparam int BIT_MAN_RD  = 29;
    localparam logic [31:0] CFG_MASK  = 32'h01FF_E000;
    localparam logic [31:0] CFG_RESET = 32'h0008_0000;
    // ----------------------------------------
    // Frame layout and timing
    // ----------------------------------------
    localparam logic [15:0] FCS_BYTES   = 16'h0004;
    localparam logic [15:0] HDR_FCS     = 16'h0012;
    localparam logic [15:0] LEN_LIMIT   = 16'h0600;
    localparam logic [15:0] PAUSE_TYPE  = 16'h8808;
    localparam logic [15:0] PAUSE_OP    = 16'h0001;
    localparam logic [15:0] IDX_TYPE    = 16'h000D;
    localparam logic [15:0] IDX_OP      = 16'h000F;
    localparam logic [15:0] IDX_QNT     = 16'h0011;
    localparam logic [5:0]  MAN_BITS    = 6'h20;
    localparam logic [5:0]  TURN_BIT    = 6'h0E;
    // Half periods of the management clock for codes 0..5
    localparam logic [5:0] HALF_8  = 6'h04;
    localparam logic [5:0] HALF_16 = 6'h08;
    localparam logic [5:0] HALF_32 = 6'h10;
    localparam logic [5:0] HALF_48 = 6'h18;
    localparam logic [5:0] HALF_64 = 6'h20;
    localparam logic [5:0] HALF_96 = 6'h30;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        MS_IDLE  = 2'b01,
        MS_SHIFT = 2'b10
    } emc_mstate_e;
    typedef struct packed {
        logic       vld;
        logic       last;
        logic [7:0] data;
    } emc_rx_s;
    typedef struct packed {
        logic        vld;
        logic [15:0] addr;
        logic [7:0]  data;
    } emc_mem_s;
    typedef struct packed {
        logic        commit;
        logic        drop;
        logic [15:0] len;
    } emc_done_s;
endpackage

// ===== verilog/emc_rx_cfg.sv
// Receive frame filter, configuration registers and management clock generator
`timescale 1ns/1ps
module emc_rx_cfg (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata,
    input  wire emc_pkg::emc_rx_s   rx_in,
    input  wire logic               fcs_bad,
    input  wire logic               csum_bad,
    input  wire logic               da_match,
    input  wire logic               hash_match,
    input  wire logic               type_match,
    input  wire logic               copy_all_frames,
    input  wire logic               pfc_negotiated,
    output emc_pkg::emc_mem_s       mem_out,
    output emc_pkg::emc_done_s      frame_done,
    output logic                    csum_engine_en,
    output logic [1:0]              bus_width_sel,
    output logic                    pause_tx_req,
    output logic [15:0]             pause_quanta,
    output logic                    mdc,
    output logic                    mdio_o,
    output logic                    mdio_oe,
    input  wire logic               mdio_i
);
    import emc_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] cfg;     // Configuration word
        logic [31:0] man;     // Management shift word
        logic        man_rd;  // Current operation is a read
        emc_mstate_e ms;      // Management sequencer
        logic [5:0]  dcnt;    // Divider count
        logic        mdc;     // Management clock level
        logic        sbit;    // Sampled input bit
        logic [5:0]  bitn;    // Bits shifted so far
        logic [15:0] pcnt;    // Valid pause frames seen
        logic [15:0] rcnt;    // Bytes received in this frame
        logic [31:0] hold;    // Four byte delay for FCS removal
        logic [15:0] lenf;    // Type or length field
        logic [15:0] opc;     // Pause opcode
        logic [15:0] qnt;     // Pause quanta
        emc_mem_s    mem;     // Memory write
        emc_done_s   done;    // End of frame verdict
        logic        ptx;     // Pause transmit request
        logic [31:0] rdata;   // Read data
    } emc_st_s;

    emc_st_s st;
    emc_st_s next_st;

    // ----------------------------------------
    // Decoded configuration
    // ----------------------------------------
    logic       strip;        // Remove FCS
    logic [1:0] ofs;          // Buffer byte offset
    logic [2:0] div_code;     // Divider code
    logic [5:0] half;         // Half period in master clocks
    logic [15:0] flen;        // Length including current byte
    logic [15:0] qnt_now;     // Quanta including current byte
    logic       is_pause;     // Pause type and opcode seen
    logic       pause_ok;     // Valid pause frame at end
    logic       len_bad;      // Length field check failed
    logic       other_drop;   // Drop not tied to pause handling
    logic       accept;       // Address filtering passed

    assign strip    = st.cfg[BIT_STRIP];
    assign ofs      = st.cfg[BIT_OFS_LO +: 2];
    assign div_code = st.cfg[BIT_DIV_LO +: 3];
    assign flen     = st.rcnt + 16'h0001;
    assign qnt_now  = (st.rcnt == IDX_QNT) ? {st.qnt[7:0], rx_in.data} : st.qnt;

    // Divider table, undefined codes held at the slowest rate
    always_comb begin
        case (div_code)
            3'h0:    half = HALF_8;
            3'h1:    half = HALF_16;
            3'h2:    half = HALF_32;
            3'h3:    half = HALF_48;
            3'h4:    half = HALF_64;
            3'h5:    half = HALF_96;
            default: half = HALF_96;
        endcase
    end

    // Frame verdict terms, valid in the cycle of the last byte
    always_comb begin
        is_pause   = (st.lenf == PAUSE_TYPE) && (st.opc == PAUSE_OP);
        pause_ok   = is_pause && !fcs_bad;
        len_bad    = st.cfg[BIT_LENDIS] && (st.lenf < LEN_LIMIT)
                     && ((flen < HDR_FCS) || ((flen - HDR_FCS) < st.lenf));
        other_drop = fcs_bad || (st.cfg[BIT_CSUM] && csum_bad) || len_bad;
        if (st.cfg[BIT_PCPY] && pause_ok) begin
            accept = da_match;
        end else begin
            accept = da_match || hash_match || type_match || copy_all_frames;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.mem.vld     = 1'b0;
        next_st.done.commit = 1'b0;
        next_st.done.drop   = 1'b0;
        next_st.ptx         = 1'b0;
        next_st.rdata       = 32'h0000_0000;
        // Register writes
        if (reg_wr && reg_addr == OFS_CFG) begin
            next_st.cfg = reg_wdata & CFG_MASK;
        end
        // Register reads, answered next cycle
        if (reg_rd) begin
            case (reg_addr)
                OFS_CFG:  next_st.rdata = st.cfg;
                OFS_MAN:  next_st.rdata = st.man;
                OFS_STAT: next_st.rdata = {31'h0000_0000, st.ms == MS_SHIFT};
                OFS_PCNT: next_st.rdata = {16'h0000, st.pcnt};
                default:  next_st.rdata = 32'h0000_0000;
            endcase
        end
        // Management sequencer
        case (st.ms)
            MS_IDLE: begin
                next_st.mdc  = 1'b0;
                next_st.dcnt = 6'h00;
                if (reg_wr && reg_addr == OFS_MAN) begin
                    next_st.man    = reg_wdata;
                    next_st.man_rd = reg_wdata[BIT_MAN_RD];
                    next_st.bitn   = 6'h00;
                    next_st.ms     = MS_SHIFT;
                end
            end
            MS_SHIFT: begin
                if (st.dcnt == half - 6'h01) begin
                    next_st.dcnt = 6'h00;
                    next_st.mdc  = !st.mdc;
                    if (!st.mdc) begin
                        // Rising edge, sample the line
                        next_st.sbit = mdio_i;
                    end else begin
                        // Falling edge, advance one bit
                        next_st.man  = {st.man[30:0], st.sbit};
                        next_st.bitn = st.bitn + 6'h01;
                        if (st.bitn == MAN_BITS - 6'h01) begin
                            next_st.ms = MS_IDLE;
                        end
                    end
                end else begin
                    next_st.dcnt = st.dcnt + 6'h01;
                end
            end
            default: next_st.ms = MS_IDLE;
        endcase
        // Receive path
        if (rx_in.vld) begin
            next_st.rcnt = rx_in.last ? 16'h0000 : flen;
            next_st.hold = {st.hold[23:0], rx_in.data};
            if (st.rcnt <= IDX_TYPE) begin
                next_st.lenf = {st.lenf[7:0], rx_in.data};
            end else if (st.rcnt <= IDX_OP) begin
                next_st.opc = {st.opc[7:0], rx_in.data};
            end else if (st.rcnt <= IDX_QNT) begin
                // Quanta bytes shift in one per byte, high byte first
                next_st.qnt = {st.qnt[7:0], rx_in.data};
            end
            // Byte to memory, held back four bytes when stripping
            if (!strip) begin
                next_st.mem.vld  = 1'b1;
                next_st.mem.data = rx_in.data;
                next_st.mem.addr = st.rcnt + {14'h0000, ofs};
            end else if (st.rcnt >= FCS_BYTES) begin
                next_st.mem.vld  = 1'b1;
                next_st.mem.data = st.hold[31:24];
                next_st.mem.addr = st.rcnt - FCS_BYTES + {14'h0000, ofs};
            end
            if (rx_in.last) begin
                next_st.done.commit = accept && !other_drop;
                next_st.done.drop   = !(accept && !other_drop);
                next_st.done.len    = strip ? flen - FCS_BYTES : flen;
                next_st.lenf        = 16'h0000;
                next_st.opc         = 16'h0000;
                next_st.qnt         = 16'h0000;
                if (pause_ok) begin
                    next_st.pcnt = st.pcnt + 16'h0001;
                    if (st.cfg[BIT_PEN] && qnt_now != 16'h0000 && !pfc_negotiated) begin
                        next_st.ptx = 1'b1;
                        next_st.qnt = qnt_now;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            st        <= '0;
            st.cfg    <= CFG_RESET;
            st.ms     <= MS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata      = st.rdata;
    assign mem_out        = st.mem;
    assign frame_done     = st.done;
    assign csum_engine_en = st.cfg[BIT_CSUM];
    assign bus_width_sel  = st.cfg[BIT_BW_LO +: 2];
    assign pause_tx_req   = st.ptx;
    assign pause_quanta   = st.qnt;
    assign mdc            = st.mdc;
    assign mdio_o         = st.man[31];
    assign mdio_oe        = (st.ms == MS_SHIFT) && !(st.man_rd && st.bitn >= TURN_BIT);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [5:0] hi_cnt; // Master clocks since management clock last changed
    // Held at zero while idle, so the first half period of an operation is
    // measured from its start and not from the end of the previous one
    always_ff @(posedge clock) begin
        if (rst || (st.ms == MS_IDLE) || (st.mdc != next_st.mdc)) begin
            hi_cnt <= 6'h00;
        end else begin
            hi_cnt <= hi_cnt + 6'h01;
        end
    end

    // Last byte of a frame is on the stream
    logic fin;
    assign fin = rx_in.vld && rx_in.last;

    // One assertion per device rule, sampled on the master clock
    AST_CSUM: assert property (@(posedge clock) disable iff (rst)
        fin && st.cfg[BIT_CSUM] && csum_bad |=> frame_done.drop && !frame_done.commit)
        else $error("bad checksum frame not dropped");
    AST_PCOPY: assert property (@(posedge clock) disable iff (rst)
        fin && st.cfg[BIT_PCPY] && pause_ok && !da_match |=> !frame_done.commit)
        else $error("pause frame copied");
    AST_DAPAUSE: assert property (@(posedge clock) disable iff (rst)
        fin && pause_ok && da_match && !other_drop |=> frame_done.commit)
        else $error("address matched pause frame lost");
    AST_PCNT: assert property (@(posedge clock) disable iff (rst)
        fin && pause_ok |=> st.pcnt == $past(st.pcnt) + 16'h0001)
        else $error("pause counter not advanced");
    AST_DIV: assert property (@(posedge clock) disable iff (rst)
        $changed(st.mdc) && st.cfg == $past(st.cfg) |-> $past(hi_cnt) == half - 6'h01)
        else $error("management clock half period wrong");
    AST_DIVHI: assert property (@(posedge clock) disable iff (rst)
        div_code[2:1] == 2'b11 |-> half == HALF_96)
        else $error("undefined divider code not slowest");
    AST_MDC_IDLE: assert property (@(posedge clock) disable iff (rst)
        st.ms == MS_IDLE ##1 st.ms == MS_IDLE |-> !mdc)
        else $error("management clock active while idle");
    AST_FCS: assert property (@(posedge clock) disable iff (rst)
        fin && strip |=> frame_done.len == $past(flen) - FCS_BYTES)
        else $error("stripped length wrong");
    AST_LEN: assert property (@(posedge clock) disable iff (rst)
        fin && len_bad |=> frame_done.drop)
        else $error("short frame kept");
    AST_OFS: assert property (@(posedge clock) disable iff (rst)
        rx_in.vld && st.rcnt == 16'h0000 && !strip |=> mem_out.vld
        && mem_out.addr == {14'h0000, $past(ofs)})
        else $error("first byte not at offset");
    AST_PTX: assert property (@(posedge clock) disable iff (rst)
        fin && pause_ok && st.cfg[BIT_PEN] && qnt_now != 16'h0000 && !pfc_negotiated
        |=> pause_tx_req)
        else $error("pause not honoured");
    AST_QNT: assert property (@(posedge clock) disable iff (rst)
        fin && pause_ok && st.cfg[BIT_PEN] && qnt_now != 16'h0000 && !pfc_negotiated
        |=> pause_quanta == $past(qnt_now))
        else $error("pause quanta not kept");
    AST_OE_IDLE: assert property (@(posedge clock) disable iff (rst)
        st.ms == MS_IDLE |-> !mdio_oe)
        else $error("management data driven while idle");

    // Main scenarios that the bench is expected to reach
    COV_PAUSE: cover property (@(posedge clock) disable iff (rst) fin && pause_ok);
    COV_STRIP: cover property (@(posedge clock) disable iff (rst)
        strip ##1 frame_done.commit);
    COV_MAN: cover property (@(posedge clock) disable iff (rst)
        st.ms == MS_SHIFT ##1 st.ms == MS_IDLE);
    COV_LENDROP: cover property (@(posedge clock) disable iff (rst) fin && len_bad);
    COV_SLOWDIV: cover property (@(posedge clock) disable iff (rst)
        st.ms == MS_SHIFT && div_code[2:1] == 2'b11);
endmodule
